/* File: hdl/prcg_bank.sv */
`timescale 1ns/1ns
// What this block does
// R01 - bit 29 holds calibrator in reset
// R02 - bits 16-18 reset timers nine to eleven
// R03 - bit 14 resets system configuration unit
// R04 - bit 12 resets first serial peripheral
// R05 - bit 8 resets analog converter interface
// R06 - bits 5,4 reset serial ports six, one
// R07 - bit 0 holds advanced timer in reset
// R08 - reserved bits keep reset value always
// R09 - bits 24,22 gate transfer engine clocks
// R10 - bit 12 gates checksum unit clock
// R11 - bits 0-5 gate io ports A-F
// R12 - bit 7 gates usb controller clock
// R13 - bit 0 gates external memory controller
// R14 - bit 29 gates analog output clock
// R15 - bit 28 gates power interface clock
// R16 - bit 11 gates window watchdog clock
// R17 - zero wait, word/half/byte accesses accepted
// R18 - all control bits zero after reset
// R19 - glitch-free gates, resets held level
module prcg_bank (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [prcg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [prcg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output prcg_pkg::prcg_bus2_reset_type periph_reset,
  output prcg_pkg::prcg_sysbus_gate_type sysbus_clock_gate,
  output prcg_pkg::prcg_bus1_gate_type bus1_clock_gate
);
  import prcg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // decoding and write merge

  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr);
    logic hit;
    hit = 1'b0;
    case (addr)
      OFF_BUS2_PERIPHERAL_RESET: hit = 1'b1;
      OFF_SYSBUS_CLOCK_ENABLE_ONE: hit = 1'b1;
      OFF_SYSBUS_CLOCK_ENABLE_TWO: hit = 1'b1;
      OFF_SYSBUS_CLOCK_ENABLE_THREE: hit = 1'b1;
      OFF_BUS1_CLOCK_ENABLE: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : addr_hit

  function automatic logic [2:0] addr_index(input logic [ADDR_W-1:0] addr);
    logic [2:0] idx;
    idx = IDX_BUS2_RESET;
    case (addr)
      OFF_SYSBUS_CLOCK_ENABLE_ONE: idx = IDX_SYS_EN_ONE;
      OFF_SYSBUS_CLOCK_ENABLE_TWO: idx = IDX_SYS_EN_TWO;
      OFF_SYSBUS_CLOCK_ENABLE_THREE: idx = IDX_SYS_EN_THREE;
      OFF_BUS1_CLOCK_ENABLE: idx = IDX_BUS1_EN;
      default: idx = IDX_BUS2_RESET;
    endcase
    return idx;
  endfunction : addr_index

  // byte strobes select lanes, so byte and half-word stores touch only their lanes
  function automatic logic [31:0] merge(
    input logic [31:0] old_value,
    input logic [31:0] data,
    input logic [3:0] strb,
    input logic [31:0] mask
  );
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return ((old_value & ~lanes) | (data & lanes)) & mask;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // write channel

  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [31:0] ctrl_regs [NUM_REGS];

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire have_aw = aw_held | aw_take;
  wire have_w = w_held | w_take;
  wire do_write = have_aw & have_w & ~s_axi_bvalid;
  wire [ADDR_W-1:0] wr_addr = aw_held ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data_q : s_axi_wdata;
  wire [3:0] wr_strb = w_held ? w_strb_q : s_axi_wstrb;
  wire wr_hit = addr_hit(wr_addr);
  wire [2:0] wr_idx = addr_index(wr_addr);

  // no wait states: each channel is ready unless its item is parked or a write response is pending
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid; // R17
  assign s_axi_wready = ~w_held & ~s_axi_bvalid; // R17

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr_q <= '0;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (do_write) begin
      w_held <= 1'b0;
    end else if (w_take) begin
      w_held <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  // the mask keeps reserved and uncovered bits at zero whatever is written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        ctrl_regs[i] <= REG_RESET_VALUE; // R18
      end
    end else if (do_write && wr_hit) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        if (wr_idx == 3'(i)) begin
          ctrl_regs[i] <= merge(ctrl_regs[i], wr_data, wr_strb, WRITE_MASK[i]); // R08 R17
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel

  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire rd_hit = addr_hit(s_axi_araddr);
  wire [2:0] rd_idx = addr_index(s_axi_araddr);
  wire [31:0] rd_value = rd_hit ? ctrl_regs[rd_idx] : 32'h00000000;

  assign s_axi_arready = ~s_axi_rvalid; // R17

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // peripheral reset lines

  // straight from flip-flops, so each reset stays level while its bit is set
  wire [31:0] bus2_rst = ctrl_regs[IDX_BUS2_RESET];
  assign periph_reset.calibrator = bus2_rst[CALIBRATOR_RESET_BIT]; // R01 R19
  assign periph_reset.timer_eleven = bus2_rst[TIMER_ELEVEN_RESET_BIT]; // R02
  assign periph_reset.timer_ten = bus2_rst[TIMER_TEN_RESET_BIT]; // R02
  assign periph_reset.timer_nine = bus2_rst[TIMER_NINE_RESET_BIT]; // R02
  assign periph_reset.sysconfig = bus2_rst[SYSCONFIG_RESET_BIT]; // R03
  assign periph_reset.serial_periph_one = bus2_rst[SERIAL_PERIPH_ONE_RESET_BIT]; // R04
  assign periph_reset.analog_converter = bus2_rst[ANALOG_CONVERTER_RESET_BIT]; // R05
  assign periph_reset.serial_port_six = bus2_rst[SERIAL_PORT_SIX_RESET_BIT]; // R06
  assign periph_reset.serial_port_one = bus2_rst[SERIAL_PORT_ONE_RESET_BIT]; // R06
  assign periph_reset.advanced_timer = bus2_rst[ADVANCED_TIMER_RESET_BIT]; // R07

  ////////////////////////////////////////////////////////////////////////////
  // clock gate enables
  // enables change only just after a rising edge, while a latch-type gate cell
  // is opaque; such a cell therefore never cuts a pulse short

  wire [31:0] sys_en1 = ctrl_regs[IDX_SYS_EN_ONE];
  wire [31:0] sys_en2 = ctrl_regs[IDX_SYS_EN_TWO];
  wire [31:0] sys_en3 = ctrl_regs[IDX_SYS_EN_THREE];
  wire [31:0] bus1_en = ctrl_regs[IDX_BUS1_EN];

  assign sysbus_clock_gate.transfer_engine_two = sys_en1[TRANSFER_ENGINE_TWO_BIT]; // R09 R19
  assign sysbus_clock_gate.transfer_engine_one = sys_en1[TRANSFER_ENGINE_ONE_BIT]; // R09
  assign sysbus_clock_gate.checksum_unit = sys_en1[CHECKSUM_UNIT_BIT]; // R10
  assign sysbus_clock_gate.io_port = sys_en1[IO_PORT_F_BIT:IO_PORT_A_BIT]; // R11
  assign sysbus_clock_gate.usb_controller = sys_en2[USB_CONTROLLER_BIT]; // R12
  assign sysbus_clock_gate.external_memory_ctrl = sys_en3[EXTERNAL_MEMORY_CTRL_BIT]; // R13

  assign bus1_clock_gate.serial_port_eight = bus1_en[SERIAL_PORT_EIGHT_BIT];
  assign bus1_clock_gate.serial_port_seven = bus1_en[SERIAL_PORT_SEVEN_BIT];
  assign bus1_clock_gate.analog_output = bus1_en[ANALOG_OUTPUT_BIT]; // R14
  assign bus1_clock_gate.power_interface = bus1_en[POWER_INTERFACE_BIT]; // R15
  assign bus1_clock_gate.can_two = bus1_en[CAN_TWO_BIT];
  assign bus1_clock_gate.can_one = bus1_en[CAN_ONE_BIT];
  assign bus1_clock_gate.i2c = bus1_en[I2C_THREE_BIT:I2C_ONE_BIT];
  assign bus1_clock_gate.serial_port_five_to_two = bus1_en[SERIAL_PORT_FIVE_BIT:SERIAL_PORT_TWO_BIT];
  assign bus1_clock_gate.spi_three = bus1_en[SPI_THREE_BIT];
  assign bus1_clock_gate.spi_two = bus1_en[SPI_TWO_BIT];
  assign bus1_clock_gate.window_watchdog = bus1_en[WINDOW_WATCHDOG_BIT]; // R16

  // protection bits carry no meaning for this bank
  wire unused_prot = ^{s_axi_awprot, s_axi_arprot};
endmodule : prcg_bank

/* File: hdl/prcg_pkg.sv */
package prcg_pkg;
  localparam int ADDR_W = 12;
  localparam int NUM_REGS = 5;
  localparam logic [ADDR_W-1:0] OFF_BUS2_PERIPHERAL_RESET = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_SYSBUS_CLOCK_ENABLE_ONE = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_SYSBUS_CLOCK_ENABLE_TWO = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_SYSBUS_CLOCK_ENABLE_THREE = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_BUS1_CLOCK_ENABLE = 12'h010;
  localparam logic [2:0] IDX_BUS2_RESET = 3'h0;
  localparam logic [2:0] IDX_SYS_EN_ONE = 3'h1;
  localparam logic [2:0] IDX_SYS_EN_TWO = 3'h2;
  localparam logic [2:0] IDX_SYS_EN_THREE = 3'h3;
  localparam logic [2:0] IDX_BUS1_EN = 3'h4;
  localparam logic [31:0] REG_RESET_VALUE = 32'h00000000;
  // only documented control bits are writable, everything else stays at zero
  localparam logic [31:0] WRITE_MASK [NUM_REGS] = '{
    32'h20075131, 32'h0140103F, 32'h00000080, 32'h00000001, 32'hF6FEC800};
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CALIBRATOR_RESET_BIT = 29;
  localparam int TIMER_ELEVEN_RESET_BIT = 18;
  localparam int TIMER_TEN_RESET_BIT = 17;
  localparam int TIMER_NINE_RESET_BIT = 16;
  localparam int SYSCONFIG_RESET_BIT = 14;
  localparam int SERIAL_PERIPH_ONE_RESET_BIT = 12;
  localparam int ANALOG_CONVERTER_RESET_BIT = 8;
  localparam int SERIAL_PORT_SIX_RESET_BIT = 5;
  localparam int SERIAL_PORT_ONE_RESET_BIT = 4;
  localparam int ADVANCED_TIMER_RESET_BIT = 0;
  localparam int TRANSFER_ENGINE_TWO_BIT = 24;
  localparam int TRANSFER_ENGINE_ONE_BIT = 22;
  localparam int CHECKSUM_UNIT_BIT = 12;
  localparam int IO_PORT_A_BIT = 0;
  localparam int IO_PORT_F_BIT = 5;
  localparam int USB_CONTROLLER_BIT = 7;
  localparam int EXTERNAL_MEMORY_CTRL_BIT = 0;
  localparam int SERIAL_PORT_EIGHT_BIT = 31;
  localparam int SERIAL_PORT_SEVEN_BIT = 30;
  localparam int ANALOG_OUTPUT_BIT = 29;
  localparam int POWER_INTERFACE_BIT = 28;
  localparam int CAN_TWO_BIT = 26;
  localparam int CAN_ONE_BIT = 25;
  localparam int I2C_THREE_BIT = 23;
  localparam int I2C_ONE_BIT = 21;
  localparam int SERIAL_PORT_FIVE_BIT = 20;
  localparam int SERIAL_PORT_TWO_BIT = 17;
  localparam int SPI_THREE_BIT = 15;
  localparam int SPI_TWO_BIT = 14;
  localparam int WINDOW_WATCHDOG_BIT = 11;

  typedef struct packed {
    logic calibrator;
    logic timer_eleven;
    logic timer_ten;
    logic timer_nine;
    logic sysconfig;
    logic serial_periph_one;
    logic analog_converter;
    logic serial_port_six;
    logic serial_port_one;
    logic advanced_timer;
  } prcg_bus2_reset_type;

  typedef struct packed {
    logic transfer_engine_two;
    logic transfer_engine_one;
    logic checksum_unit;
    logic [5:0] io_port;
    logic usb_controller;
    logic external_memory_ctrl;
  } prcg_sysbus_gate_type;

  typedef struct packed {
    logic serial_port_eight;
    logic serial_port_seven;
    logic analog_output;
    logic power_interface;
    logic can_two;
    logic can_one;
    logic [2:0] i2c;
    logic [3:0] serial_port_five_to_two;
    logic spi_three;
    logic spi_two;
    logic window_watchdog;
  } prcg_bus1_gate_type;
endpackage : prcg_pkg

/* File: test/prcg_bank_sva.sv */
`timescale 1ns/1ns
module prcg_bank_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [prcg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire prcg_pkg::prcg_bus2_reset_type periph_reset,
  input wire prcg_pkg::prcg_sysbus_gate_type sysbus_clock_gate,
  input wire prcg_pkg::prcg_bus1_gate_type bus1_clock_gate
);
  import prcg_pkg::*;
  // bits that no register implements must always read back zero
  localparam logic [31:0] USED = 32'hF7FFD9BF;
  wire logic [9:0] r = periph_reset;
  wire logic [31:0] bus2_view = {2'h0, r[9], 10'h0, r[8:6], 1'h0, r[5], 1'h0, r[4], 3'h0, r[3], 2'h0, r[2:1], 3'h0, r[0]};
  ////////////////////////////////////////
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_in;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_in;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_ans;
    s_wr_in |=> s_axi_bvalid;
  endproperty
  property p_rd_ans;
    s_rd_in |=> s_axi_rvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_rst_zero;
    !$past(aresetn) |-> {periph_reset, sysbus_clock_gate, bus1_clock_gate} == '0;
  endproperty
  // controls may only move as a write is taken, in the cycle bvalid rises, so the gates see no stray edges
  property p_out_hold;
    $past(aresetn) && !$rose(s_axi_bvalid) |-> $stable({periph_reset, sysbus_clock_gate, bus1_clock_gate});
  endproperty
  property p_rsvd;
    s_axi_rvalid |-> (s_axi_rdata & ~USED) == '0;
  endproperty
  property p_bus2_rd;
    s_rd_in ##0 s_axi_araddr == OFF_BUS2_PERIPHERAL_RESET |=> s_axi_rdata == $past(bus2_view);
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  a_rst_zero: assert property (p_rst_zero) else $error("controls not cleared");
  a_out_hold: assert property (p_out_hold) else $error("control moved without write");
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  a_bus2_rd: assert property (p_bus2_rd) else $error("reset lines differ from register");
endmodule : prcg_bank_sva

bind prcg_bank prcg_bank_sva prcg_bank_sva_inst (.*);

/* File: test/prcg_bank_tb.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module prcg_bank_tb;
  import prcg_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [2:0] s_axi_awprot = 3'h0;
  logic [2:0] s_axi_arprot = 3'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  prcg_bus2_reset_type periph_reset;
  prcg_sysbus_gate_type sysbus_clock_gate;
  prcg_bus1_gate_type bus1_clock_gate;
  logic [31:0] m [NUM_REGS] = '{default: REG_RESET_VALUE};
  logic [31:0] st = 32'h0000D360;
  logic [38:0] exp_b [$];
  logic [33:0] exp_r [$];
  logic [38:0] eb;
  logic [33:0] er;
  logic [ADDR_W-1:0] ra;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  always #50 aclk = ~aclk;
  prcg_bank prcg_bank_inst (.*);
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction : rnd
  function automatic logic [36:0] outs();
    return {m[0][29], m[0][18:16], m[0][14], m[0][12], m[0][8], m[0][5:4], m[0][0], m[1][24], m[1][22],
      m[1][12], m[1][5:0], m[2][7], m[3][0], m[4][31:28], m[4][26:25], m[4][23:17], m[4][15:14], m[4][11]};
  endfunction : outs
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  // handshakes are sampled at the falling edge, where nothing is in motion
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    int bd;
    logic ta;
    logic tw;
    logic tb;
    logic hit;
    logic [31:0] ln;
    n = 0;
    bd = int'(rnd() % 3);
    tb = 1'h0;
    ln = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    hit = a[1:0] == 2'h0 && a <= OFF_BUS1_CLOCK_ENABLE;
    if (hit) begin
      m[a[4:2]] = (m[a[4:2]] & ~ln | d & ln) & WRITE_MASK[a[4:2]];
    end
    exp_b.push_back({hit ? RESP_OKAY : RESP_SLVERR, outs()});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    // address and data are offered together; each is dropped once it is taken
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= bd == 0;
    while (!tb) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      @(posedge aclk);
      n++;
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (n == bd) s_axi_bready <= 1'h1;
    end
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a);
    int n;
    int rdl;
    logic ta;
    logic tr;
    n = 0;
    rdl = int'(rnd() % 3);
    tr = 1'h0;
    exp_r.push_back((a[1:0] == 2'h0 && a <= OFF_BUS1_CLOCK_ENABLE) ? {RESP_OKAY, m[a[4:2]]} : {RESP_SLVERR, 32'h0});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= rdl == 0;
    while (!tr) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid && s_axi_rready;
      @(posedge aclk);
      n++;
      if (ta) s_axi_arvalid <= 1'h0;
      if (n == rdl) s_axi_rready <= 1'h1;
    end
    s_axi_rready <= 1'h0;
  endtask : rd
  ////////////////////////////////////////
  always @(posedge aclk) begin
    cyc++;
    if (s_axi_bvalid && s_axi_bready) begin
      eb = exp_b.pop_front();
      `CHK("bresp and controls", eb, {s_axi_bresp, periph_reset, sysbus_clock_gate, bus1_clock_gate})
    end
    if (s_axi_rvalid && s_axi_rready) begin
      er = exp_r.pop_front();
      `CHK("rresp and rdata", er, {s_axi_rresp, s_axi_rdata})
    end
    // the run needs a few thousand cycles; a hang lands here and fails
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 7; i++) rd(12'(4 * i));
    rd(12'h002);
    for (int i = 0; i < 5; i++) begin
      for (int b = 0; b < 32; b++) begin
        wr(12'(4 * i), 32'h1 << b, 4'hF);
        rd(12'(4 * i));
      end
    end
    repeat (200) begin
      ra = 12'(4 * (rnd() % 6));
      wr(ra, rnd(), 4'(rnd()));
      rd(ra);
    end
    for (int i = 0; i < 5; i++) wr(12'(4 * i), 32'hFFFFFFFF, 4'hF);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    m = '{default: REG_RESET_VALUE};
    for (int i = 0; i < 5; i++) rd(12'(4 * i));
    finish_test();
  end
endmodule : prcg_bank_tb
